// ===== icl_pkg.sv
// icl_pkg: map, fields, timing and types of the carrier local control
package icl_pkg;

  // clock and timing
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned POR_HOLD_MS    = 200;
  localparam int unsigned POR_HOLD_CYC   = POR_HOLD_MS * 1000 * CLK_MHZ;
  localparam int unsigned STROBE_NS      = 40;
  localparam logic [7:0]  STROBE_CYC     = 8'((STROBE_NS * CLK_MHZ + 999) / 1000);
  localparam int unsigned BOOT_NS        = 100;
  localparam logic [7:0]  BOOT_CYC       = 8'((BOOT_NS * CLK_MHZ + 999) / 1000);
  localparam int unsigned IP_TIMEOUT_CYC = 1024;

  // local bus addresses
  localparam logic [23:0] A_PAGE_CTRL   = 24'hF00000;
  localparam logic [23:0] A_STROBE_CTRL = 24'hF00002;
  localparam logic [23:0] A_IRQ_STAT    = 24'hF00008;
  localparam logic [23:0] A_DMA_STAT    = 24'hF00009;
  localparam logic [23:0] A_MISC_STAT   = 24'hF0000A;
  localparam logic [23:0] A_BERR_CLR    = 24'hF00028;
  localparam logic [23:0] A_STROBE_TRIG = 24'hF00038;
  localparam logic [23:0] WINDOW_BASE   = 24'h400000;
  localparam logic [23:0] IPIO_BASE     = 24'hF00400;

  // reset values
  localparam logic [7:0] PAGE_CTRL_RST   = 8'h00;
  localparam logic [7:0] STROBE_CTRL_RST = 8'h00;

  // page_and_width_control fields
  localparam int PC_MEM     = 0;
  localparam int PC_WIDE    = 1;
  localparam int PC_BANK_LO = 2;
  localparam int PC_BANK_HI = 3;
  // strobe_and_error_control fields
  localparam int SC_TMR  = 0;
  localparam int SC_WIDE = 1;
  localparam int SC_TOE  = 2;
  localparam int SC_EXT  = 3;
  // misc_status fields
  localparam int MS_FLAG = 0;
  localparam int MS_JMP  = 1;

  // positions in the synchronised pin vector
  localparam int SY_ACK  = 0;
  localparam int SY_TMR  = 1;
  localparam int SY_EXT  = 2;
  localparam int SY_HRST = 3;
  localparam int SY_SER  = 4;
  localparam int SY_BRG  = 5;
  localparam int SY_FIFO = 6;
  localparam int SY_JMP  = 7;
  localparam int SY_IRQ0 = 9;
  localparam int SY_IRQ1 = 13;
  localparam int SY_MODULE_TRANSFER_REQUEST_0 = 17;
  localparam int SY_MODULE_TRANSFER_REQUEST_1 = 21;
  localparam int SY_W    = 25;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01
  } icl_cyc_e;

  // two request lines per slot, line 0 in the lower bit
  function automatic logic [7:0] icl_pair(input logic [3:0] l0, input logic [3:0] l1);
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < 4; i++) begin
      v[2*i]   = l0[i];
      v[2*i+1] = l1[i];
    end
    return v;
  endfunction

endpackage

// ===== icl_sync.sv
// icl_sync: three-stage pin synchroniser with agreement filter
module icl_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         mclk_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] sync_o
);
  import icl_pkg::*;

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] out_r;
  logic [W-1:0] out_nxt;

  // a change counts once stages two and three agree
  always_comb begin
    out_nxt = out_r;
    for (int i = 0; i < W; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        out_nxt[i] = s3_r[i];
      end
    end
  end

  // stage one is read by stage two only
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      out_r <= '0;
    end else begin
      s1_r  <= pin_i;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign sync_o = out_r;

endmodule // icl_sync

// ===== icl_ctrl.sv
// icl_ctrl: local control, paging, strobe, timeout, status and resets
module icl_ctrl #(
  parameter int unsigned RESET_HOLD_CYC = icl_pkg::POR_HOLD_CYC,
  parameter int unsigned TIMEOUT_CYC    = icl_pkg::IP_TIMEOUT_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  // local bus of the processor
  input  wire logic [23:0] dsp_addr_i,
  input  wire logic        dsp_rd_i,
  input  wire logic        dsp_wr_i,
  input  wire logic [31:0] dsp_wdata_i,
  output logic      [31:0] dsp_rdata_o,
  output logic             dsp_ready_o,
  // module cycle side
  input  wire logic        module_acknowledge_n_i,
  input  wire logic [31:0] ip_rdata_i,
  output logic      [3:0]  ip_slot_sel_o,
  output logic             ip_mem_space_o,
  output logic             ip_wide_o,
  output logic             flash_page_o,
  // strobe routing
  input  wire logic        timer1_i,
  input  wire logic        ext_trigger_i,
  output logic             module_strobe_n_o,
  // module requests and jumpers
  input  wire logic [3:0]  module_request_line_0_n_i,
  input  wire logic [3:0]  module_request_line_1_n_i,
  input  wire logic [3:0]  module_transfer_request_0_n_i,
  input  wire logic [3:0]  module_transfer_request_1_n_i,
  input  wire logic [1:0]  jumper_n_i,
  // other interrupt sources and host reset
  input  wire logic        serial_irq_n_i,
  input  wire logic        bridge_irq_n_i,
  input  wire logic        bridge_fifo_ready_i,
  input  wire logic        host_system_reset_bit_i,
  // resets and interrupt lines
  output logic             dsp_reset_n_o,
  output logic             module_reset_n_o,
  output logic             int0_n_o,
  output logic             int1_n_o,
  output logic             int2_n_o,
  output logic             int3_n_o
);
  import icl_pkg::*;

  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  localparam int HW = $clog2(RESET_HOLD_CYC + 1);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [SY_W-1:0] pin_raw;
  logic [SY_W-1:0] pin_s;
  logic            tmr_s;

  // active-low pins except jumper_n_i are turned to active-high before syncing
  assign pin_raw = {~module_transfer_request_1_n_i,
                    ~module_transfer_request_0_n_i,
                    ~module_request_line_1_n_i,
                    ~module_request_line_0_n_i,
                    jumper_n_i,
                    bridge_fifo_ready_i,
                    ~bridge_irq_n_i,
                    ~serial_irq_n_i,
                    host_system_reset_bit_i,
                    ext_trigger_i,
                    timer1_i,
                    ~module_acknowledge_n_i};

  icl_sync #(
    .W (SY_W)
  ) u_sync (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .pin_i  (pin_raw),
    .sync_o (pin_s)
  );

  assign tmr_s = pin_s[SY_TMR];

  ////////////////////////////////////////////////////////////////////////
  // address decode

  logic       acc;
  logic       win_hit;
  logic       io_hit;
  logic       ip_hit;
  logic [1:0] bank;
  logic [1:0] slot;
  logic       clr_wr;
  logic       trig_wr;
  logic       sw_mode;
  logic [7:0] irq_stat;
  logic [7:0] dma_stat;
  logic [7:0] misc_stat;
  logic [7:0] page_r;
  logic [7:0] sctl_r;
  logic       flag_r;

  assign acc     = dsp_rd_i | dsp_wr_i;
  assign bank    = page_r[PC_BANK_HI:PC_BANK_LO];
  assign win_hit = dsp_addr_i[23:22] == WINDOW_BASE[23:22];
  assign io_hit  = dsp_addr_i[23:10] == IPIO_BASE[23:10];
  // window goes to a slot only when the memory bit is set
  assign ip_hit  = acc & ((win_hit & page_r[PC_MEM]) | io_hit);
  assign slot    = io_hit ? dsp_addr_i[9:8] : bank;
  assign clr_wr  = dsp_wr_i & (dsp_addr_i == A_BERR_CLR);
  assign trig_wr = dsp_wr_i & (dsp_addr_i == A_STROBE_TRIG);
  assign sw_mode = sctl_r[SC_TMR] & ~sctl_r[SC_EXT];

  // status images
  assign irq_stat  = icl_pair(pin_s[SY_IRQ0+:4], pin_s[SY_IRQ1+:4]);
  assign dma_stat  = icl_pair(pin_s[SY_MODULE_TRANSFER_REQUEST_0+:4], pin_s[SY_MODULE_TRANSFER_REQUEST_1+:4]);
  assign misc_stat = {5'h00, pin_s[SY_JMP+:2], flag_r};

  ////////////////////////////////////////////////////////////////////////
  // control registers and error flag

  logic [7:0] page_nxt;
  logic [7:0] sctl_nxt;
  logic       flag_nxt;
  logic       flash_r;
  logic       flash_nxt;
  logic       tmo;

  // write-only controls; timeout set wins over a clear
  always_comb begin
    page_nxt = page_r;
    sctl_nxt = sctl_r;
    if (dsp_wr_i && dsp_addr_i == A_PAGE_CTRL) begin
      page_nxt = dsp_wdata_i[7:0];
    end
    if (dsp_wr_i && dsp_addr_i == A_STROBE_CTRL) begin
      sctl_nxt = dsp_wdata_i[7:0];
    end
    flag_nxt = tmo | (flag_r & ~clr_wr);
    flash_nxt = ~page_nxt[PC_MEM];
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      page_r <= PAGE_CTRL_RST;
      sctl_r <= STROBE_CTRL_RST;
      flag_r <= 1'b0;
      flash_r <= ~PAGE_CTRL_RST[PC_MEM];
    end else begin
      page_r <= page_nxt;
      sctl_r <= sctl_nxt;
      flag_r <= flag_nxt;
      flash_r <= flash_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus cycle sequencer

  icl_cyc_e     st_r;
  icl_cyc_e     st_nxt;
  logic [TW-1:0] cnt_r;
  logic [TW-1:0] cnt_nxt;
  logic [3:0]   sel_r;
  logic [3:0]   sel_nxt;
  logic         mem_r;
  logic         mem_nxt;
  logic         wide_r;
  logic         wide_nxt;
  logic         rdy_r;
  logic         rdy_nxt;
  logic [31:0]  rdata_r;
  logic [31:0]  rdata_nxt;

  // a stuck slot cycle is ended by the timer
  assign tmo = (st_r == ST_WAIT) && !pin_s[SY_ACK] &&
               (cnt_r == TW'(TIMEOUT_CYC - 1));

  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    sel_nxt   = sel_r;
    mem_nxt   = mem_r;
    wide_nxt  = wide_r;
    rdy_nxt   = 1'b0;
    rdata_nxt = rdata_r;
    case (st_r)
      ST_IDLE: begin
        if (ip_hit) begin
          st_nxt   = ST_WAIT;
          cnt_nxt  = '0;
          sel_nxt  = 4'h1 << slot;
          mem_nxt  = ~io_hit;
          // pair width chosen by the upper slot bit
          wide_nxt = slot[1] ? sctl_r[SC_WIDE] : page_r[PC_WIDE];
        end else if (dsp_rd_i) begin
          rdy_nxt = (dsp_addr_i == A_IRQ_STAT) || (dsp_addr_i == A_DMA_STAT) ||
                    (dsp_addr_i == A_MISC_STAT);
          case (dsp_addr_i)
            A_IRQ_STAT:  rdata_nxt = {24'h000000, irq_stat};
            A_DMA_STAT:  rdata_nxt = {24'h000000, dma_stat};
            A_MISC_STAT: rdata_nxt = {24'h000000, misc_stat};
            default:     rdata_nxt = rdata_r;
          endcase
        end else if (dsp_wr_i) begin
          rdy_nxt = (dsp_addr_i == A_PAGE_CTRL) || (dsp_addr_i == A_STROBE_CTRL) ||
                    clr_wr || trig_wr;
        end
      end
      ST_WAIT: begin
        if (pin_s[SY_ACK]) begin
          st_nxt  = ST_IDLE;
          rdy_nxt = 1'b1;
          sel_nxt = 4'h0;
          // access is always 32 bits; a narrow pair zeroes the top half
          rdata_nxt = wide_r ? ip_rdata_i : {16'h0000, ip_rdata_i[15:0]};
        end else if (tmo) begin
          st_nxt    = ST_IDLE;
          rdy_nxt   = 1'b1;
          sel_nxt   = 4'h0;
          rdata_nxt = 32'h00000000;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      default: begin
        st_nxt  = ST_IDLE;
        sel_nxt = 4'h0;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      st_r    <= ST_IDLE;
      cnt_r   <= '0;
      sel_r   <= 4'h0;
      mem_r   <= 1'b0;
      wide_r  <= 1'b0;
      rdy_r   <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      sel_r   <= sel_nxt;
      mem_r   <= mem_nxt;
      wide_r  <= wide_nxt;
      rdy_r   <= rdy_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // strobe routing

  logic [7:0] scnt_r;
  logic [7:0] scnt_nxt;
  logic       strb_r;
  logic       strb_nxt;

  // external trigger first, then timer select
  always_comb begin
    scnt_nxt = (scnt_r != 8'h00) ? scnt_r - 8'h01 : 8'h00;
    if (trig_wr && sw_mode) begin
      scnt_nxt = STROBE_CYC;
    end
    if (sctl_r[SC_EXT]) begin
      strb_nxt = ~pin_s[SY_EXT];
    end else if (sctl_r[SC_TMR]) begin
      strb_nxt = ~(scnt_nxt != 8'h00);
    end else begin
      strb_nxt = ~tmr_s;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      scnt_r <= 8'h00;
      strb_r <= 1'b1;
    end else begin
      scnt_r <= scnt_nxt;
      strb_r <= strb_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reset hold, boot pulse and interrupt lines

  logic [HW-1:0] hold_r;
  logic [HW-1:0] hold_nxt;
  logic          ract_r;
  logic          ract;
  logic          rstn_r;
  logic          rstn_nxt;
  logic [7:0]    boot_r;
  logic [7:0]    boot_nxt;
  logic [3:0]    intn_r;
  logic [3:0]    intn_nxt;

  assign ract = (hold_r != '0) | pin_s[SY_HRST];

  always_comb begin
    hold_nxt = (hold_r != '0) ? hold_r - 1'b1 : hold_r;
    rstn_nxt = ~((hold_nxt != '0) | pin_s[SY_HRST]);
    boot_nxt = (boot_r != 8'h00) ? boot_r - 8'h01 : 8'h00;
    if (ract_r && !ract) begin
      boot_nxt = BOOT_CYC;
    end
    intn_nxt[0] = ~(pin_s[SY_SER] | (flag_r & sctl_r[SC_TOE]));
    intn_nxt[1] = ~(pin_s[SY_BRG] | (boot_nxt != 8'h00));
    intn_nxt[2] = ~pin_s[SY_FIFO];
    intn_nxt[3] = ~(|irq_stat);
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      hold_r <= HW'(RESET_HOLD_CYC);
      ract_r <= 1'b1;
      rstn_r <= 1'b0;
      boot_r <= 8'h00;
      intn_r <= 4'hF;
    end else begin
      hold_r <= hold_nxt;
      ract_r <= ract;
      rstn_r <= rstn_nxt;
      boot_r <= boot_nxt;
      intn_r <= intn_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign dsp_rdata_o       = rdata_r;
  assign dsp_ready_o       = rdy_r;
  assign ip_slot_sel_o     = sel_r;
  assign ip_mem_space_o    = mem_r;
  assign ip_wide_o         = wide_r;
  assign flash_page_o      = flash_r;
  assign module_strobe_n_o = strb_r;
  assign dsp_reset_n_o     = rstn_r;
  assign module_reset_n_o  = rstn_r;
  assign int0_n_o          = intn_r[0];
  assign int1_n_o          = intn_r[1];
  assign int2_n_o          = intn_r[2];
  assign int3_n_o          = intn_r[3];

  ////////////////////////////////////////////////////////////////////////
  // checks

  property p_page_rst;
    @(posedge mclk_i) !nrst_i |=> (page_r == PAGE_CTRL_RST) && flash_page_o;
  endproperty
  a_page_rst: assert property (p_page_rst)
    else $error("page control not zero after reset");

  property p_page_slot;
    @(posedge mclk_i) disable iff (!nrst_i)
      (st_r == ST_IDLE && ip_hit && !io_hit)
        |=> (ip_slot_sel_o == (4'h1 << $past(bank))) && ip_mem_space_o;
  endproperty
  a_page_slot: assert property (p_page_slot)
    else $error("window slot differs from page bank");

  property p_tmo_bound;
    @(posedge mclk_i) disable iff (!nrst_i)
      (st_r == ST_WAIT) |-> (cnt_r < TW'(TIMEOUT_CYC));
  endproperty
  a_tmo_bound: assert property (p_tmo_bound)
    else $error("slot cycle outlived its timer");

  property p_tmo_end;
    @(posedge mclk_i) disable iff (!nrst_i)
      tmo |=> dsp_ready_o && flag_r && (ip_slot_sel_o == 4'h0);
  endproperty
  a_tmo_end: assert property (p_tmo_end)
    else $error("timeout did not end cycle and set flag");

  property p_flag_clr;
    @(posedge mclk_i) disable iff (!nrst_i)
      (clr_wr && !tmo) |=> !flag_r ##1 !misc_stat[MS_FLAG] || tmo;
  endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("error flag survived clear write");

  property p_toe_int;
    @(posedge mclk_i) disable iff (!nrst_i)
      (flag_r && sctl_r[SC_TOE]) |=> !int0_n_o;
  endproperty
  a_toe_int: assert property (p_toe_int)
    else $error("enabled timeout did not assert line 0");

  property p_narrow;
    @(posedge mclk_i) disable iff (!nrst_i)
      (st_r == ST_WAIT && pin_s[SY_ACK] && !wide_r)
        |=> dsp_ready_o && (dsp_rdata_o[31:16] == 16'h0000);
  endproperty
  a_narrow: assert property (p_narrow)
    else $error("narrow pair returned upper half");

  property p_req_int;
    @(posedge mclk_i) disable iff (!nrst_i)
      (|irq_stat) |=> !int3_n_o;
  endproperty
  a_req_int: assert property (p_req_int)
    else $error("module request missed line 3");

  property p_sw_strobe;
    @(posedge mclk_i) disable iff (!nrst_i)
      (trig_wr && sw_mode && !(dsp_addr_i == A_STROBE_CTRL))
        |=> !module_strobe_n_o [*2];
  endproperty
  a_sw_strobe: assert property (p_sw_strobe)
    else $error("software strobe pulse missing");

  property p_tmr_route;
    @(posedge mclk_i) disable iff (!nrst_i)
      (!sctl_r[SC_TMR] && !sctl_r[SC_EXT]) |=> (module_strobe_n_o == !$past(tmr_s));
  endproperty
  a_tmr_route: assert property (p_tmr_route)
    else $error("strobe does not follow timer 1");

  property p_ext_route;
    @(posedge mclk_i) disable iff (!nrst_i)
      (sctl_r[SC_EXT] && pin_s[SY_EXT]) |=> !module_strobe_n_o;
  endproperty
  a_ext_route: assert property (p_ext_route)
    else $error("external trigger not routed");

  property p_hold;
    @(posedge mclk_i) disable iff (!nrst_i)
      (hold_r > HW'(1)) |=> !dsp_reset_n_o && !module_reset_n_o;
  endproperty
  a_hold: assert property (p_hold)
    else $error("reset released during hold time");

  property p_boot;
    @(posedge mclk_i) disable iff (!nrst_i)
      (ract_r && !ract) |=> !int1_n_o [*8];
  endproperty
  a_boot: assert property (p_boot)
    else $error("boot pulse on line 1 missing");

endmodule // icl_ctrl

// ===== icl_ip_model.sv
// icl_ip_model: slot module that answers carrier cycles with its acknowledge
module icl_ip_model (
  input  wire logic        mclk_i,
  input  wire logic [3:0]  slot_sel_i,
  input  wire logic [3:0]  delay_i,
  input  wire logic        mute_i,
  output logic             ack_n_o,
  output logic      [31:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] cnt_r;

  ////////////////////////////////////////////////////////////////////////////////
  // start idle with the acknowledge released
  initial begin
    cnt_r   = 4'h0;
    ack_n_o = 1'b1;
    rdata_o = 32'h0F0F_0F0F;
  end

  // acknowledge after delay_i cycles; a muted module never answers
  always @(posedge mclk_i) begin
    if (slot_sel_i == 4'h0) begin
      cnt_r   <= 4'h0;
      ack_n_o <= 1'b1;
      rdata_o <= ~rdata_o; // released data toggles so stale values never match
    end else if (cnt_r < delay_i) begin
      cnt_r <= cnt_r + 4'h1;
    end else if (!mute_i) begin
      ack_n_o <= 1'b0;
      rdata_o <= {slot_sel_i, 12'hABC, slot_sel_i, 12'h123};
    end
  end
endmodule // icl_ip_model

// ===== icl_ctrl_tb.sv
// icl_ctrl_tb: self-checking bench for the carrier local control
module icl_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import icl_pkg::*;

  logic        mclk_i, nrst_i, dsp_rd_i, dsp_wr_i, ack_n, timer1_i, ext_trigger_i;
  logic        serial_n, bridge_n, fifo, host_bit, mute, wide, mem, flash, strobe_n;
  logic        ready, dsp_rst_n, mod_rst_n, int0_n, int1_n, int2_n, int3_n;
  logic        bok, mem_seen, wide_seen;
  logic [23:0] addr;
  logic [31:0] wdata, rdata, ip_rdata, bq, x;
  logic [3:0]  sel, dly, rq0_n, rq1_n, dm0_n, dm1_n, sel_seen, e;
  logic [1:0]  jmp_n;
  int          err_total, samples_checked, low_cnt;

  icl_ctrl #(.RESET_HOLD_CYC(50), .TIMEOUT_CYC(16)) dut (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .dsp_addr_i(addr), .dsp_rd_i(dsp_rd_i),
    .dsp_wr_i(dsp_wr_i), .dsp_wdata_i(wdata), .dsp_rdata_o(rdata), .dsp_ready_o(ready),
    .module_acknowledge_n_i(ack_n), .ip_rdata_i(ip_rdata), .ip_slot_sel_o(sel),
    .ip_mem_space_o(mem), .ip_wide_o(wide), .flash_page_o(flash), .timer1_i(timer1_i),
    .ext_trigger_i(ext_trigger_i), .module_strobe_n_o(strobe_n),
    .module_request_line_0_n_i(rq0_n), .module_request_line_1_n_i(rq1_n),
    .module_transfer_request_0_n_i(dm0_n), .module_transfer_request_1_n_i(dm1_n),
    .jumper_n_i(jmp_n), .serial_irq_n_i(serial_n), .bridge_irq_n_i(bridge_n),
    .bridge_fifo_ready_i(fifo), .host_system_reset_bit_i(host_bit),
    .dsp_reset_n_o(dsp_rst_n), .module_reset_n_o(mod_rst_n), .int0_n_o(int0_n),
    .int1_n_o(int1_n), .int2_n_o(int2_n), .int3_n_o(int3_n));

  icl_ip_model u_ip (.mclk_i(mclk_i), .slot_sel_i(sel), .delay_i(dly), .mute_i(mute),
    .ack_n_o(ack_n), .rdata_o(ip_rdata));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and strobe low-cycle counter
  always #2 mclk_i = ~mclk_i;
  always @(negedge mclk_i) if (strobe_n === 1'b0) low_cnt++;

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one access: strobe for one cycle, then wait for the answer
  task automatic bus(input logic wr, input logic [23:0] a, input logic [31:0] d);
    int n;
    n = 0;
    repeat (6) @(negedge mclk_i);
    addr = a;
    wdata = d;
    dsp_wr_i = wr;
    dsp_rd_i = !wr;
    @(negedge mclk_i);
    dsp_wr_i = 1'b0;
    dsp_rd_i = 1'b0;
    do begin
      @(posedge mclk_i);
      #1;
      n++;
      if (n == 1) begin
        sel_seen = sel;
        mem_seen = mem;
        wide_seen = wide;
      end
    end while (ready !== 1'b1 && n < 40);
    bok = (ready === 1'b1);
    bq = rdata;
    @(negedge mclk_i); // hand back at a falling edge
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // reset hold, default page and boot pulse
  task automatic t_reset;
    chk("dsp_rst_n", 0, dsp_rst_n);
    chk("flash_page", 1, flash);
    repeat (45) @(negedge mclk_i);
    chk("mod_rst_n", 0, mod_rst_n);
    repeat (12) @(negedge mclk_i);
    chk("mod_rst_n", 1, mod_rst_n);
    chk("int1_n", 0, int1_n);
    repeat (30) @(negedge mclk_i);
    chk("int1_n", 1, int1_n);
    host_bit = 1'b1;
    repeat (10) @(negedge mclk_i);
    chk("dsp_rst_n", 0, dsp_rst_n);
    host_bit = 1'b0;
    repeat (90) @(negedge mclk_i);
    chk("dsp_rst_n", 1, dsp_rst_n);
  endtask

  // request, transfer and jumper status
  task automatic t_status;
    rq0_n = 4'b1110;
    rq1_n = 4'b0111;
    dm0_n = 4'b1101;
    dm1_n = 4'b1011;
    jmp_n = 2'b10;
    bus(0, A_IRQ_STAT, 0);
    chk("irq_stat", 32'h81, bq);
    chk("int3_n", 0, int3_n);
    bus(0, A_DMA_STAT, 0);
    chk("dma_stat", 32'h24, bq);
    bus(0, A_MISC_STAT, 0);
    chk("misc_stat", 32'h4, bq);
    rq0_n = 4'hF;
    rq1_n = 4'hF;
    repeat (8) @(negedge mclk_i);
    chk("int3_n", 1, int3_n);
    bus(1, A_IRQ_STAT, 8'hFF);
    chk("ro_write_ok", 0, bok);
    dm0_n = 4'hF;
    dm1_n = 4'hF;
  endtask

  // paged slot windows, narrow and wide
  task automatic t_page;
    for (int i = 0; i < 4; i++) begin
      e = 4'(1 << i);
      x = {e, 12'hABC, e, 12'h123};
      bus(1, A_PAGE_CTRL, 32'(1 + 4 * i));
      chk("flash_page", 0, flash);
      bus(0, WINDOW_BASE + 24'(i), 0);
      chk("slot_sel", 32'(e), 32'(sel_seen));
      chk("mem_space", 1, mem_seen);
      chk("narrow_data", {16'h0, x[15:0]}, bq);
      chk("wide_sel", 0, wide_seen);
    end
    dly = 4'h8;
    bus(1, A_PAGE_CTRL, 8'h03);
    bus(0, WINDOW_BASE, 0);
    chk("wide_ab", {4'h1, 12'hABC, 4'h1, 12'h123}, bq);
    chk("wide_sel", 1, wide_seen);
    bus(1, A_STROBE_CTRL, 8'h02);
    bus(1, A_PAGE_CTRL, 8'h09);
    bus(0, WINDOW_BASE, 0);
    chk("wide_cd", {4'h4, 12'hABC, 4'h4, 12'h123}, bq);
    chk("wide_sel", 1, wide_seen);
    bus(0, IPIO_BASE + 24'h100, 0);
    chk("io_sel", 32'h2, 32'(sel_seen));
    chk("io_mem", 0, mem_seen);
    bus(1, A_PAGE_CTRL, 8'h00);
    chk("flash_page", 1, flash);
    dly = 4'h1;
  endtask

  // cycle timeout, error flag and interrupt lines
  task automatic t_timeout;
    bus(1, A_STROBE_CTRL, 8'h04);
    bus(1, A_PAGE_CTRL, 8'h01);
    mute = 1'b1;
    bus(0, WINDOW_BASE, 0);
    chk("timeout_ok", 1, bok);
    chk("timeout_data", 0, bq);
    bus(0, A_MISC_STAT, 0);
    chk("err_flag", 1, 32'(bq[0]));
    chk("int0_n", 0, int0_n);
    bus(1, A_BERR_CLR, 8'h5A);
    bus(0, A_MISC_STAT, 0);
    chk("err_flag", 0, 32'(bq[0]));
    chk("int0_n", 1, int0_n);
    bus(1, A_STROBE_CTRL, 8'h00);
    bus(0, WINDOW_BASE, 0);
    repeat (2) @(negedge mclk_i);
    chk("int0_n_masked", 1, int0_n);
    bus(1, A_BERR_CLR, 8'h00);
    mute = 1'b0;
    serial_n = 1'b0;
    bridge_n = 1'b0;
    fifo = 1'b1;
    repeat (8) @(negedge mclk_i);
    chk("int0_n", 0, int0_n);
    chk("int1_n", 0, int1_n);
    chk("int2_n", 0, int2_n);
    serial_n = 1'b1;
    bridge_n = 1'b1;
    fifo = 1'b0;
  endtask

  // strobe source routing and software pulse
  task automatic t_strobe;
    bus(1, A_STROBE_CTRL, 8'h09);
    ext_trigger_i = 1'b1;
    repeat (8) @(negedge mclk_i);
    chk("strobe_ext", 0, strobe_n);
    ext_trigger_i = 1'b0;
    bus(1, A_STROBE_CTRL, 8'h00);
    timer1_i = 1'b1;
    repeat (8) @(negedge mclk_i);
    chk("strobe_tmr", 0, strobe_n);
    timer1_i = 1'b0;
    bus(1, A_STROBE_CTRL, 8'h01);
    timer1_i = 1'b1;
    low_cnt = 0;
    bus(1, A_STROBE_TRIG, 32'hFFFF_FFFF);
    repeat (20) @(negedge mclk_i);
    chk("strobe_len", 32'(STROBE_CYC), low_cnt);
    timer1_i = 1'b0;
    bus(1, A_STROBE_CTRL, 8'h00);
    repeat (8) @(negedge mclk_i);
    low_cnt = 0;
    bus(1, A_STROBE_TRIG, 0);
    repeat (20) @(negedge mclk_i);
    chk("strobe_none", 0, low_cnt);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {mclk_i, nrst_i, dsp_rd_i, dsp_wr_i, timer1_i, ext_trigger_i} = 6'h00;
    {fifo, host_bit, mute, addr, wdata} = 59'h0;
    {serial_n, bridge_n} = 2'b11;
    {rq0_n, rq1_n, dm0_n, dm1_n} = 16'hFFFF;
    jmp_n = 2'b11;
    dly = 4'h1;
    low_cnt = 0;
    err_total = 0;
    samples_checked = 0;
    repeat (20) @(negedge mclk_i);
    nrst_i = 1'b1;
    t_reset();
    t_status();
    t_page();
    t_timeout();
    t_strobe();
    results();
  end

  // watchdog against a hung sequence
  initial begin
    repeat (20000) @(posedge mclk_i);
    err_total++;
    $display("MISMATCH watchdog expected done seen hang");
    results();
  end
endmodule // icl_ctrl_tb
